// ===== include/rtdrd_regs.svh
// Constants of the temperature-input bus slave: offsets, field positions, timing.
// Assumes inclusion by its bare name from the package, compiled ahead of the design modules.
`ifndef RTDRD_REGS_SVH
`define RTDRD_REGS_SVH

// ----------------------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------------------
`define RTDRD_FIXED_HI        3'h7      // Address bits 15..13 are always one
`define RTDRD_STRAP_LSB       8         // Strap field drives bits 12..8
`define RTDRD_CH_LSB          3         // Channel number on bits 4..3
`define RTDRD_MOD_BIT         2         // Module select bit
`define RTDRD_MOD0_SEL        3'h0      // Pattern for the first module
`define RTDRD_MOD1_SEL        3'h4      // Pattern for the second module
`define RTDRD_VALUE_M0C1      16'he800  // First channel of first module at default straps
`define RTDRD_VALUE_M1C1      16'he804
`define RTDRD_VALUE_M0C2      16'he808
`define RTDRD_VALUE_M1C2      16'he80c
`define RTDRD_VALUE_M0C3      16'he810
`define RTDRD_VALUE_M1C3      16'he814
`define RTDRD_VALUE_M0C4      16'he818
`define RTDRD_VALUE_M1C4      16'he81c

// ----------------------------------------------------------------------------
// Data word layout and timing
// ----------------------------------------------------------------------------
`define RTDRD_CODE_LSB        3         // Code sits in bits 14..3
`define RTDRD_CODE_MAX        12'hfff   // Full scale, 7ff8 in the word
`define RTDRD_CONV_NS         40000     // Per-channel conversion time
`define RTDRD_CLK_NS          40        // System clock period
`define RTDRD_CONV_CYC        ((`RTDRD_CONV_NS / `RTDRD_CLK_NS) - 1)

`endif

// ===== include/rtdrd_pkg.sv
// Types shared by the temperature-input bus slave modules.
// Assumes the constants header is on the include path.
`include "rtdrd_regs.svh"
package rtdrd_pkg;
  typedef enum logic [1:0] {
    RTDRD_IDLE = 2'b00,
    RTDRD_CONV = 2'b01,
    RTDRD_DONE = 2'b10
  } rtdrd_conv_type;
  typedef logic [11:0] rtdrd_code_type;
endpackage

// ===== logic/rtdrd_sync.sv
// Three-stage input synchroniser; a change counts once stages two and three agree.
// Assumes the input is asynchronous to clk_sys_i.
`timescale 1ns/10ps
module rtdrd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // ----------------------------------------------------------------------------
  // Shift chain; stage one feeds only stage two
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      sync_o <= '0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          sync_o[i] <= s3[i];
        end
      end
    end
  end
endmodule

// ===== logic/rtdrd_conv.sv
// Per-module conversion sequencer: walks four channels, one slot per channel.
// Assumes the converter result arrives synchronised with a done pulse.
`timescale 1ns/10ps
module rtdrd_conv
  import rtdrd_pkg::*;
#(
  parameter int NCH    = 4,
  parameter int CYC    = `RTDRD_CONV_CYC
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_i,
  input  wire logic                     adc_done_i,
  input  wire rtdrd_code_type           adc_code_i,
  output logic      [$clog2(NCH)-1:0]   adc_chan_o,
  output logic                          adc_start_o,
  output rtdrd_code_type                value_o [NCH]
);
  rtdrd_conv_type state;
  logic [15:0]    slot;
  wire            slot_end = (slot == 16'(CYC));
  // ----------------------------------------------------------------------------
  // One channel per slot of 40 us, four slots per full pass
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state       <= RTDRD_IDLE;
      slot        <= 16'h0000;
      adc_chan_o  <= '0;
      adc_start_o <= 1'b0;
      for (int i = 0; i < NCH; i++) value_o[i] <= 12'h000;
    end else begin
      adc_start_o <= 1'b0;
      slot        <= slot_end ? 16'h0000 : slot + 16'h0001;
      unique case (state)
        RTDRD_IDLE: begin
          adc_start_o <= 1'b1;
          state       <= RTDRD_CONV;
        end
        RTDRD_CONV: begin
          if (adc_done_i) begin
            value_o[adc_chan_o] <= adc_code_i; // Result must land inside its slot
            state               <= RTDRD_DONE;
          end
        end
        RTDRD_DONE: ;
        default: state <= RTDRD_IDLE;
      endcase
      if (slot_end) begin
        adc_chan_o <= adc_chan_o + 1'b1; // Wraps after the last channel
        state      <= RTDRD_IDLE;
      end
    end
  end
endmodule

// ===== logic/rtdrd_top.sv
// Read-only backplane slave for a carrier with two four-channel temperature modules.
// Assumes backplane address, strobe and straps are asynchronous pins.
`timescale 1ns/10ps
// Contract
// - Passive slave: never starts transfers, answers reads only.
// - Addressed channel's converted value is returned as one data word.
// - Address bits 15..13 must be one to select the unit.
// - Bits 12..8 compare to straps; fitted strap is zero, open is one.
// - Channels one to four sit at base plus 0, 8, 10h, 18h.
// - Second module channels lie four above the first module's.
// - Bits 2..0: 000 selects module one, 100 module two.
// - Unit base anywhere from E000h to FF00h in 256-byte steps.
// - Word: bit 15 zero, code in 14..3, bits 2..0 zero.
// - Code linear over -50..150 C, 0000h to 7FF8h.
// - Each conversion under 40 us; a four-channel pass 160 us.
// - Four channels per module, eight with two modules.
module rtdrd_top
  import rtdrd_pkg::*;
#(
  parameter int NMOD = 2,
  parameter int NCH  = 4
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  input  wire logic [15:0]            bus_addr_i,
  input  wire logic                   bus_read_n_i,
  input  wire logic [4:0]             unit_address_strap_field_i,
  input  wire logic [NMOD-1:0]        adc_done_i,
  input  wire logic [NMOD*12-1:0]     adc_code_i,
  output logic      [NMOD-1:0]        adc_start_o,
  output logic      [NMOD*2-1:0]      adc_chan_o,
  output logic      [15:0]            bus_data_o,
  output logic                        bus_data_oe_o,
  output logic                        bus_ack_o
);
  // ----------------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------------
  logic [15:0] addr_s;
  logic        rd_n_s;
  logic [4:0]  strap_s;
  rtdrd_sync #(.W(22)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   ({bus_addr_i, bus_read_n_i, unit_address_strap_field_i}),
    .sync_o    ({addr_s, rd_n_s, strap_s})
  );

  // ----------------------------------------------------------------------------
  // Converters, one sequencer per module
  // ----------------------------------------------------------------------------
  rtdrd_code_type vals [NMOD][NCH];
  logic [NMOD-1:0] start_w;
  logic [NMOD*2-1:0] chan_w;
  generate
    for (genvar m = 0; m < NMOD; m++) begin : g_mod
      rtdrd_conv #(.NCH(NCH)) u_conv (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .adc_done_i  (adc_done_i[m]),
        .adc_code_i  (adc_code_i[m*12 +: 12]),
        .adc_chan_o  (chan_w[m*2 +: 2]),
        .adc_start_o (start_w[m]),
        .value_o     (vals[m])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  // Open strap reads one, fitted strap zero, so straps are the address bits
  function automatic logic unit_hit(input logic [15:0] a, input logic [4:0] s);
    unit_hit = (a[15:13] == `RTDRD_FIXED_HI) && (a[12:8] == s);
  endfunction
  wire       hit_unit = unit_hit(addr_s, strap_s);
  wire       ch_ok    = (addr_s[7:5] == 3'h0);                   // only four channels
  wire [2:0] mod_bits = addr_s[2:0];
  wire       mod_ok   = (mod_bits == `RTDRD_MOD0_SEL) || (mod_bits == `RTDRD_MOD1_SEL);
  wire       mod_sel  = addr_s[`RTDRD_MOD_BIT];
  wire [1:0] ch_sel   = addr_s[`RTDRD_CH_LSB +: 2];
  wire       sel      = hit_unit && ch_ok && mod_ok && !rd_n_s;
  wire [11:0] code_w  = vals[mod_sel][ch_sel];
  wire [15:0] word_w  = {1'b0, code_w, 3'h0};

  // ----------------------------------------------------------------------------
  // Read answer; no write path exists at all
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bus_data_o    <= 16'h0000;
      bus_data_oe_o <= 1'b0;
      bus_ack_o     <= 1'b0;
      adc_start_o   <= '0;
      adc_chan_o    <= '0;
    end else begin
      bus_data_o    <= sel ? word_w : 16'h0000;
      bus_data_oe_o <= sel;
      bus_ack_o     <= sel;
      adc_start_o   <= start_w;
      adc_chan_o    <= chan_w;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  property p_undriven_miss;
    @(posedge clk_sys_i) disable iff (rst_i) !sel |=> !bus_data_oe_o;
  endproperty
  a_undriven_miss: assert property (p_undriven_miss) else $error("data driven on miss");
  property p_hi_bits;
    @(posedge clk_sys_i) disable iff (rst_i) bus_data_oe_o |-> $past(addr_s[15:13]) == 3'h7;
  endproperty
  a_hi_bits: assert property (p_hi_bits) else $error("high bits not all one");
  property p_strap;
    @(posedge clk_sys_i) disable iff (rst_i) bus_data_oe_o |-> $past(addr_s[12:8]) == $past(strap_s);
  endproperty
  a_strap: assert property (p_strap) else $error("strap mismatch answered");
  property p_word_fmt;
    @(posedge clk_sys_i) disable iff (rst_i) bus_data_oe_o |-> !bus_data_o[15] && bus_data_o[2:0] == 3'h0;
  endproperty
  a_word_fmt: assert property (p_word_fmt) else $error("word layout wrong");
  property p_mod_sel;
    @(posedge clk_sys_i) disable iff (rst_i) bus_data_oe_o |-> $past(addr_s[1:0]) == 2'h0;
  endproperty
  a_mod_sel: assert property (p_mod_sel) else $error("bad module select answered");
  property p_value;
    @(posedge clk_sys_i) disable iff (rst_i) sel |=> bus_data_o[14:3] == $past(code_w);
  endproperty
  a_value: assert property (p_value) else $error("wrong channel value");
  property p_read_only;
    @(posedge clk_sys_i) disable iff (rst_i) rd_n_s |=> !bus_ack_o;
  endproperty
  a_read_only: assert property (p_read_only) else $error("answered non-read");
  property p_chan_range;
    @(posedge clk_sys_i) disable iff (rst_i) bus_data_oe_o |-> $past(addr_s[7:5]) == 3'h0;
  endproperty
  a_chan_range: assert property (p_chan_range) else $error("channel offset out of range");
endmodule

// ===== sim/rtdrd_adc_model.sv
// Converter model for one module: answers each start with a done pulse and a code.
// Assumes start and channel come from the design on clk_sys_i.
`timescale 1ns/10ps
module rtdrd_adc_model #(
  parameter logic MID = 1'b0
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [1:0]  chan_i,
  output logic             done_o,
  output logic      [11:0] code_o
);
  logic [3:0] cnt;
  // Answer eight cycles after start, far inside the slot
  // Stands in for the carrier-clocked converter; its clock never reaches the design
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
    end else if (start_i) begin
      cnt <= 4'h8;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  // Code is inverted outside the done cycle, so a late capture shows up
  assign done_o = (cnt == 4'h1);
  assign code_o = done_o ? {1'b1, MID, chan_i, 8'h5a} : ~{1'b1, MID, chan_i, 8'h5a};
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the temperature-input bus slave.
// Assumes the converter model sits on each module's converter port.
`timescale 1ns/10ps
module tb_top;
  import rtdrd_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        rd_n      = 1'b1;
  logic [15:0] addr      = 16'he800;
  logic [4:0]  straps    = 5'h08;
  logic [1:0]  done, start;
  logic [23:0] code;
  logic [3:0]  chan;
  logic [15:0] data;
  logic        oe, ack;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  int          t0;
  // ----------------------------------------------------------------------------
  // Clock, timeout and design
  // ----------------------------------------------------------------------------
  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      end_sim();
    end
  end
  rtdrd_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_addr_i(addr), .bus_read_n_i(rd_n),
    .unit_address_strap_field_i(straps), .adc_done_i(done), .adc_code_i(code), .adc_start_o(start),
    .adc_chan_o(chan), .bus_data_o(data), .bus_data_oe_o(oe), .bus_ack_o(ack));
  for (genvar m = 0; m < 2; m++) begin : g_adc
    rtdrd_adc_model #(.MID(1'(m))) u_adc (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start[m]),
      .chan_i(chan[m*2+:2]), .done_o(done[m]), .code_o(code[m*12+:12]));
  end
  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic [15:0] exp_word(int m, int c);
    return {1'b0, 1'b1, m[0], c[1:0], 8'h5a, 3'b000};
  endfunction
  task automatic check(logic ok, string msg);
    checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // Held read; the answer is awaited under a bound, then release is watched
  task automatic rd(logic [15:0] a, logic [15:0] exp);
    int i;
    @(posedge clk_sys_i);
    addr <= a;
    rd_n <= 1'b0;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(negedge clk_sys_i);
    check(ack === 1'b1 && oe === 1'b1 && data === exp, "read word");
    @(posedge clk_sys_i);
    rd_n <= 1'b1;
    for (i = 0; i < 20 && oe !== 1'b0; i++) @(negedge clk_sys_i);
    check(oe === 1'b0 && ack === 1'b0 && data === 16'h0000, "release");
  endtask
  // Access that must stay unanswered for longer than the normal latency
  task automatic nord(logic [15:0] a, logic rn);
    @(posedge clk_sys_i);
    addr <= a;
    rd_n <= rn;
    repeat (12) @(negedge clk_sys_i);
    check(oe === 1'b0 && ack === 1'b0 && data === 16'h0000, "refused");
    @(posedge clk_sys_i);
    rd_n <= 1'b1;
    // A one-cycle release would be filtered by the pin synchroniser
    repeat (6) @(posedge clk_sys_i);
  endtask
  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_early();
    rd(16'he818, 16'h0000);
  endtask
  // Slot spacing of the first module's sequencer
  task automatic t_pass();
    @(posedge start[0]);
    @(negedge clk_sys_i);
    t0 = cyc;
    @(posedge start[0]);
    @(negedge clk_sys_i);
    check(cyc - t0 == 1000, "slot length");
  endtask
  task automatic t_all();
    while (cyc < 8300) @(negedge clk_sys_i);
    for (int i = 0; i < 8; i++) rd(16'he800 | 16'(i << 2), exp_word(i % 2, i / 2));
  endtask
  task automatic t_straps();
    @(posedge clk_sys_i);
    straps <= 5'h1f;
    rd(16'hff1c, exp_word(1, 3));
    nord(16'he81c, 1'b0);
    @(posedge clk_sys_i);
    straps <= 5'h00;
    rd(16'he000, exp_word(0, 0));
    @(posedge clk_sys_i);
    straps <= 5'h08;
  endtask
  // Bad low bits, high channels, wrong fixed bits, and a non-read
  task automatic t_refuse();
    logic [15:0] bad [9] = '{16'he801, 16'he802, 16'he803, 16'he820, 16'he840, 16'he8e0, 16'h6800,
      16'ha800, 16'hc800};
    foreach (bad[i]) nord(bad[i], 1'b0);
    nord(16'he800, 1'b1);
  endtask
  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_early();
    t_pass();
    t_all();
    t_straps();
    t_refuse();
    end_sim();
  end
endmodule
